// ===== hdl/ctp_map.svh
`ifndef CTP_MAP_SVH
`define CTP_MAP_SVH

// ==========================================================================
// Register offsets on the 4-bit register port.
`define CTP_OFS_CTRL_LO 4'h0
`define CTP_OFS_CTRL_HI 4'h1
`define CTP_OFS_DUTY_LO 4'h2
`define CTP_OFS_DUTY_HI 4'h3
`define CTP_OFS_PER_LO 4'h4
`define CTP_OFS_PER_HI 4'h5
`define CTP_OFS_CFG 4'h6
`define CTP_OFS_CNT_LO 4'h7
`define CTP_OFS_CNT_HI 4'h8

// ==========================================================================
// Fields of timer_ctrl_reg and of the configuration register.
`define CTP_BIT_FFINIT 7
`define CTP_SRC_HI 6
`define CTP_SRC_LO 4
`define CTP_BIT_RUN 3
`define CTP_MODE_HI 2
`define CTP_MODE_LO 0
`define CTP_BIT_DVSEL 0

// ==========================================================================
// Mode codes.
`define CTP_MODE_PWM8 3'h2
`define CTP_MODE_TMR16 3'h3
`define CTP_MODE_EVT16 3'h4

// ==========================================================================
// Source clock select codes.
`define CTP_SRC_SLOWEST 3'h0
`define CTP_SRC_FC_D7 3'h1
`define CTP_SRC_FC_D5 3'h2
`define CTP_SRC_FC_D3 3'h3
`define CTP_SRC_FS 3'h4
`define CTP_SRC_FC_D1 3'h5
`define CTP_SRC_FC 3'h6

// ==========================================================================
// Prescaler sizes and reset values.
`define CTP_DIV_W 11
`define CTP_FS_DIV_W 3
`define CTP_REG_RST 8'h00

`endif

// ===== hdl/ctp_pkg.sv
`include "ctp_map.svh"

package ctp_pkg;

    // ======================================================================
    // Whole state of the timer pair.
    typedef struct packed {
        logic [`CTP_DIV_W-1:0] div;
        logic [`CTP_FS_DIV_W-1:0] fs_div;
        logic slow_s1;
        logic slow_s2;
        logic slow_d;
        logic evt_s1;
        logic evt_s2;
        logic evt_d;
        logic dvsel;
        logic [1:0][7:0] ctrl;
        logic [1:0][7:0] duty_hold;
        logic [1:0][7:0] duty_act;
        logic [7:0] per_lo;
        logic [7:0] per_hi;
        logic [1:0][7:0] cnt;
        logic [1:0] ff;
        logic [1:0] pin;
        logic [1:0] irq;
        logic [7:0] rdata;
    } ctp_state_t;

endpackage

// ===== hdl/ctp_timer.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "ctp_map.svh"

// How it works
// [RQ1] PWM8: match with duty toggles flip-flop
// [RQ2] PWM8 overflow toggles again, clears, interrupts
// [RQ3] Flip-flop starts from init bit, reset 0
// [RQ4] PWM pin is inverse of flip-flop
// [RQ5] Running PWM: duty loads on interrupt
// [RQ6] Stopped: duty write loads at once
// [RQ7] PWM duty read returns active old value
// [RQ8] Software sets port latch to one
// [RQ9] Software writes duty right after interrupt
// [RQ10] Stop holds pin; init bit changed later
// [RQ11] Control bit 3 is run control
// [RQ12] Clearing bit 7 while stopped: pin high
// [RQ13] Software stops timer before stop mode
// [RQ14] 16-bit timer cascades both counters
// [RQ15] 16-bit match interrupts upper, clears count
// [RQ16] Software writes period low then high
// [RQ17] Software keeps init bit zero in cascade
// [RQ18] Period register unbuffered, takes effect immediately
// [RQ19] Event mode counts falling edges of pin
// [RQ20] Event counting resumes after match clear
// [RQ21] Event phases last two machine cycles
// [RQ22] Source select picks prescaled clock tap
module ctp_timer (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // Register port.
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Pins.
    input wire logic i_slow_clk,
    input wire logic i_event_input_pin,
    output logic [1:0] o_pwm_out_pin_n,
    // Interrupt requests; bit 1 is the cascade interrupt.
    output logic [1:0] o_timer_irq
);

    ctp_pkg::ctp_state_t s;
    ctp_pkg::ctp_state_t next_s;

    // ======================================================================
    // Tick of the selected source clock for one timer.
    function automatic logic tap(
        input logic [2:0] sel,
        input logic [`CTP_DIV_W-1:0] div,
        input logic fs_tick,
        input logic fs8_tick,
        input logic dvsel
    );
        logic t;
        t = 1'b0;
        case (sel)
            `CTP_SRC_SLOWEST: begin
                t = dvsel ? fs8_tick : (&div[10:0]);
            end
            `CTP_SRC_FC_D7: begin
                t = &div[6:0];
            end
            `CTP_SRC_FC_D5: begin
                t = &div[4:0];
            end
            `CTP_SRC_FC_D3: begin
                t = &div[2:0];
            end
            `CTP_SRC_FS: begin
                t = fs_tick;
            end
            `CTP_SRC_FC_D1: begin
                t = div[0];
            end
            `CTP_SRC_FC: begin
                t = 1'b1;
            end
            default: begin
                t = 1'b0;
            end
        endcase
        return t;
    endfunction

    // ======================================================================
    // Next-state logic.
    always_comb begin
        logic fs_tick;
        logic fs8_tick;
        logic evt_fall;
        logic cas;
        logic cas_run;
        logic cas_tick;
        logic match;
        logic ovf;
        logic [1:0] tick;
        logic [1:0] run;
        logic [1:0] pwm_run;
        logic [2:0] mode_hi;
        logic [15:0] cnt16;
        logic [15:0] per16;
        next_s = s;
        fs_tick = 1'b0;
        fs8_tick = 1'b0;
        evt_fall = 1'b0;
        cas = 1'b0;
        cas_run = 1'b0;
        cas_tick = 1'b0;
        match = 1'b0;
        ovf = 1'b0;
        tick = 2'h0;
        run = 2'h0;
        pwm_run = 2'h0;
        mode_hi = s.ctrl[1][`CTP_MODE_HI:`CTP_MODE_LO];
        cnt16 = {s.cnt[1], s.cnt[0]};
        per16 = {s.per_hi, s.per_lo};
        next_s.irq = 2'h0;

        // Prescaler and pin synchronisers.
        next_s.div = s.div + 1'b1;
        next_s.slow_s1 = i_slow_clk;
        next_s.slow_s2 = s.slow_s1;
        next_s.slow_d = s.slow_s2;
        next_s.evt_s1 = i_event_input_pin;
        next_s.evt_s2 = s.evt_s1;
        next_s.evt_d = s.evt_s2;
        fs_tick = s.slow_s2 & ~s.slow_d;
        fs8_tick = fs_tick & (&s.fs_div);
        if (fs_tick) begin
            next_s.fs_div = s.fs_div + 1'b1;
        end
        evt_fall = s.evt_d & ~s.evt_s2; // RQ19 RQ21

        for (int j = 0; j < 2; j++) begin
            tick[j] = tap(s.ctrl[j][`CTP_SRC_HI:`CTP_SRC_LO], s.div,
                fs_tick, fs8_tick, s.dvsel); // RQ22
            run[j] = s.ctrl[j][`CTP_BIT_RUN]; // RQ11
        end
        cas = (mode_hi == `CTP_MODE_TMR16) || (mode_hi == `CTP_MODE_EVT16);

        // Two independent 8-bit PWM timers.
        for (int j = 0; j < 2; j++) begin
            pwm_run[j] = run[j] && !cas &&
                (s.ctrl[j][`CTP_MODE_HI:`CTP_MODE_LO] == `CTP_MODE_PWM8);
            if (!cas && !run[j]) begin
                next_s.cnt[j] = 8'h00; // RQ11
            end else if (pwm_run[j] && tick[j]) begin
                match = (s.cnt[j] == s.duty_act[j]);
                ovf = &s.cnt[j];
                next_s.ff[j] = s.ff[j] ^ match ^ ovf; // RQ1 RQ2
                next_s.cnt[j] = s.cnt[j] + 1'b1; // RQ1 RQ2
                if (ovf) begin
                    next_s.irq[j] = 1'b1; // RQ2
                    next_s.duty_act[j] = s.duty_hold[j]; // RQ5
                end
            end
        end

        // Cascaded 16-bit timer or event counter.
        cas_run = cas && run[1]; // RQ15
        if (mode_hi == `CTP_MODE_EVT16) begin
            cas_tick = evt_fall; // RQ19 RQ20
        end else begin
            cas_tick = tick[1]; // RQ14
        end
        if (cas && !cas_run) begin
            next_s.cnt[0] = 8'h00;
            next_s.cnt[1] = 8'h00;
        end else if (cas_run && cas_tick) begin
            if (cnt16 == per16) begin
                next_s.cnt[0] = 8'h00; // RQ15 RQ20
                next_s.cnt[1] = 8'h00;
                next_s.irq[1] = 1'b1; // RQ15
            end else begin
                {next_s.cnt[1], next_s.cnt[0]} = cnt16 + 16'h0001; // RQ14
            end
        end

        // Register writes.
        if (i_wr) begin
            case (i_addr)
                `CTP_OFS_CTRL_LO, `CTP_OFS_CTRL_HI: begin
                    next_s.ctrl[i_addr[0]] = i_wdata;
                    if (!run[i_addr[0]]) begin
                        // Only a write made while stopped loads the
                        // flip-flop, so a stopping write holds the pin.
                        next_s.ff[i_addr[0]] =
                            i_wdata[`CTP_BIT_FFINIT]; // RQ3 RQ10 RQ12
                    end
                end
                `CTP_OFS_DUTY_LO, `CTP_OFS_DUTY_HI: begin
                    next_s.duty_hold[i_addr[0]] = i_wdata; // RQ5
                    if (!pwm_run[i_addr[0]]) begin
                        next_s.duty_act[i_addr[0]] = i_wdata; // RQ6
                    end
                end
                `CTP_OFS_PER_LO: begin
                    next_s.per_lo = i_wdata; // RQ18
                end
                `CTP_OFS_PER_HI: begin
                    next_s.per_hi = i_wdata; // RQ18
                end
                `CTP_OFS_CFG: begin
                    next_s.dvsel = i_wdata[`CTP_BIT_DVSEL]; // RQ22
                end
                default: begin
                end
            endcase
        end

        for (int j = 0; j < 2; j++) begin
            next_s.pin[j] = ~next_s.ff[j]; // RQ4
        end

        // Register reads, answered in the next cycle.
        next_s.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `CTP_OFS_CTRL_LO: next_s.rdata = s.ctrl[0];
                `CTP_OFS_CTRL_HI: next_s.rdata = s.ctrl[1];
                `CTP_OFS_DUTY_LO, `CTP_OFS_DUTY_HI: begin
                    if (pwm_run[i_addr[0]]) begin
                        next_s.rdata = s.duty_act[i_addr[0]]; // RQ7
                    end else begin
                        next_s.rdata = s.duty_hold[i_addr[0]];
                    end
                end
                `CTP_OFS_PER_LO: next_s.rdata = s.per_lo;
                `CTP_OFS_PER_HI: next_s.rdata = s.per_hi;
                `CTP_OFS_CFG: next_s.rdata = {7'h00, s.dvsel};
                `CTP_OFS_CNT_LO: next_s.rdata = s.cnt[0];
                `CTP_OFS_CNT_HI: next_s.rdata = s.cnt[1];
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    // ======================================================================
    // State register.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s <= '0;
            s.ctrl <= {`CTP_REG_RST, `CTP_REG_RST};
            s.ff <= 2'h0; // RQ3
            s.pin <= 2'h3; // RQ4
        end else begin
            s <= next_s;
        end
    end

    assign o_rdata = s.rdata;
    assign o_pwm_out_pin_n = s.pin;
    assign o_timer_irq = s.irq;

endmodule // ctp_timer

// ===== test/ctp_timer_properties.sv
`timescale 1ns/1ps
module ctp_timer_properties (
    // Clock, reset and register port.
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // Pins and interrupts.
    input wire logic i_slow_clk,
    input wire logic i_event_input_pin,
    input wire logic [1:0] o_pwm_out_pin_n,
    input wire logic [1:0] o_timer_irq
);
    logic run_lo;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // ==================================================================
    // Run bit of the lower timer as last written.
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_lo <= 1'b0;
        end else if (i_wr && i_addr == 4'h0) begin
            run_lo <= i_wdata[3];
        end
    end
    // ==================================================================
    // Properties.
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside its slot");
    a_unmapped_read: assert property (i_rd && i_addr > 4'h8 |=> !o_rdata)
        else $error("unmapped read not zero");
    a_ctrl_back: assert property (i_wr && i_addr == 4'h0 ##2 i_rd &&
        i_addr == 4'h0 |=> o_rdata == $past(i_wdata, 3))
        else $error("control readback wrong");
    a_pin_reset: assert property ($rose(i_arst_n) |-> &o_pwm_out_pin_n)
        else $error("pins not high after reset");
    a_irq_pulse: assert property (o_timer_irq[0] |=>
        (!o_timer_irq[0]) [*8])
        else $error("interrupt pulse too long");
    a_irq_toggle: assert property (o_timer_irq[0] |->
        o_pwm_out_pin_n[0] != $past(o_pwm_out_pin_n[0]))
        else $error("overflow without pin toggle");
    a_ff_load: assert property (i_wr && i_addr == 4'h0 && !run_lo &&
        i_wdata[3:0] == 4'h2 |-> ##2
        o_pwm_out_pin_n[0] == !$past(i_wdata[7], 2))
        else $error("stopped write did not load pin");
    a_stop_hold: assert property (i_wr && i_addr == 4'h0 && run_lo &&
        !i_wdata[3] |-> ##2 ($stable(o_pwm_out_pin_n[0])) [*6])
        else $error("pin moved after stop");
endmodule // ctp_timer_properties

bind ctp_timer ctp_timer_properties u_props (.i_clk_sys, .i_arst_n,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_slow_clk,
    .i_event_input_pin, .o_pwm_out_pin_n, .o_timer_irq);

// ===== test/ctp_timer_tb.sv
`timescale 1ns/1ps
module ctp_timer_tb;
    logic i_clk_sys, i_arst_n, i_wr, i_rd, i_slow_clk, i_event_input_pin;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata, d;
    logic [1:0] o_pwm_out_pin_n, o_timer_irq;
    logic [2:0] srcs [3] = '{3'h6, 3'h5, 3'h3};
    logic [15:0] mult [3] = '{16'h0001, 16'h0002, 16'h0008};
    logic [2:0] srcs2 [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic [15:0] ticks2 [4] = '{16'h0200, 16'h0080, 16'h00A0, 16'h0500};
    int errors, n_tests, n, k, n_irq1;
    ctp_timer u_ctp_timer (.i_clk_sys, .i_arst_n, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_slow_clk, .i_event_input_pin, .o_pwm_out_pin_n,
        .o_timer_irq);
    // ==================================================================
    // Clocks, watchdog and cascade interrupt counter.
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        i_slow_clk = 1'b0;
        forever #500 i_slow_clk = ~i_slow_clk;
    end
    initial begin
        #1ms;
        errors++;
        close_out();
    end
    always @(negedge i_clk_sys) begin
        if (o_timer_irq[1] === 1'b1) begin
            n_irq1++;
        end
    end
    // ==================================================================
    // Tasks.
    task automatic close_out;
        $display("errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    task automatic pin_wait(input logic v, output int c);
        c = 0;
        while (o_pwm_out_pin_n[0] !== v && c < 600) begin
            @(negedge i_clk_sys);
            c++;
        end
    endtask
    // Cycles the lower pin spends low in one period.
    task automatic pw(output int c);
        pin_wait(1'b0, c);
        pin_wait(1'b1, c);
    endtask
    // Cycles between two cascade interrupts, looked at off the clock edge.
    task automatic gap(output int c);
        c = 0;
        @(negedge i_clk_sys);
        while (o_timer_irq[1] !== 1'b1 && c < 5000) begin
            @(negedge i_clk_sys);
            c++;
        end
        c = 0;
        do begin
            @(negedge i_clk_sys);
            c++;
        end while (o_timer_irq[1] !== 1'b1 && c < 5000);
    endtask
    // Falling edges sent on the event pin until a cascade interrupt.
    task automatic evt(output int c);
        int s;
        s = n_irq1;
        c = 0;
        while (n_irq1 == s && c < 12) begin
            i_event_input_pin <= 1'b0;
            c++;
            repeat (8) @(posedge i_clk_sys);
            i_event_input_pin <= 1'b1;
            repeat (8) @(posedge i_clk_sys);
        end
    endtask
    // ==================================================================
    // Test sequence.
    initial begin
        i_arst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 8'h00;
        i_event_input_pin = 1'b1;
        repeat (5) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        #1;
        chk(16'(o_pwm_out_pin_n), 16'h0003);
        chk(16'(o_timer_irq), 16'h0000);
        wr(4'h0, 8'hA2);
        rd(4'h0, d);
        chk(16'(d), 16'h00A2);
        chk(16'(o_pwm_out_pin_n[0]), 16'h0000);
        wr(4'h0, 8'h02);
        repeat (2) @(posedge i_clk_sys);
        #1 chk(16'(o_pwm_out_pin_n[0]), 16'h0001);
        rd(4'hF, d);
        chk(16'(d), 16'h0000);
        $display("test control done");
        wr(4'h2, 8'h10);
        rd(4'h2, d);
        chk(16'(d), 16'h0010);
        wr(4'h0, 8'h6A);
        pw(n);
        chk(16'(n), 16'h00EF);
        wr(4'h2, 8'h40);
        rd(4'h2, d);
        chk(16'(d), 16'h0010);
        pw(n);
        chk(16'(n), 16'h00EF);
        pw(n);
        chk(16'(n), 16'h00BF);
        rd(4'h2, d);
        chk(16'(d), 16'h0040);
        pin_wait(1'b0, n);
        wr(4'h0, 8'h62);
        repeat (300) @(negedge i_clk_sys);
        chk(16'(o_pwm_out_pin_n[0]), 16'h0000);
        $display("test pwm done");
        wr(4'h4, 8'h2C);
        wr(4'h5, 8'h01);
        for (k = 0; k < 3; k++) begin
            wr(4'h1, {1'b0, srcs[k], 4'hB});
            gap(n);
            chk(16'(n), 16'h012D * mult[k]);
        end
        wr(4'h1, 8'h03);
        wr(4'h4, 8'h03);
        wr(4'h5, 8'h00);
        wr(4'h6, 8'h01);
        rd(4'h6, d);
        chk(16'(d), 16'h0001);
        for (k = 0; k < 4; k++) begin
            wr(4'h1, {1'b0, srcs2[k], 4'hB});
            gap(n);
            chk(16'(n), ticks2[k]);
        end
        $display("test cascade timer done");
        wr(4'h1, 8'h03);
        wr(4'h4, 8'h03);
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h0C);
        evt(n);
        chk(16'(n), 16'h0004);
        evt(n);
        chk(16'(n), 16'h0004);
        $display("test event counter done");
        close_out();
    end
endmodule // ctp_timer_tb
